// file: src/mpc_config_regs.sv
/*
 * motor pin and device configuration register bank: three 32-bit
 * read/write registers, brake source and action selection, speed
 * input mode decode, analog monitor and current sense pin routing,
 * supply full-scale scaling and the serial target address.
 * assumes the serial front end turns bus transfers into the simple
 * word port below, one access per strobe, at the printed offsets.
 */
`timescale 1ns/1ns
`include "mpc_consts.svh"
module mpc_config_regs
  import mpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_rd_err,
  input wire logic brake_pin,
  output logic low_side_brake_on,
  output logic align_brake_on,
  output logic speed_analog_sel,
  output logic speed_pwm_sel,
  output logic speed_freq_sel,
  output logic analog_monitor_one_en,
  output logic analog_monitor_two_en,
  output logic analog_monitor_two_on_pin38,
  output logic phase_a_sense_out_en,
  output logic phase_b_sense_out_en,
  output logic phase_c_sense_out_en,
  output logic [6:0] supply_full_scale,
  output logic supply_scale_valid,
  output logic [6:0] target_addr,
  output logic [31:0] device_setup_two_q
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [31:0] hardware_pin_setup_reg;
  logic [31:0] device_setup_one_reg;
  logic [31:0] device_setup_two_reg;

  // address decode, kept as named wires
  wire logic hit_pin = (reg_addr == `MPC_OFS_PIN_SETUP);
  wire logic hit_one = (reg_addr == `MPC_OFS_SETUP_ONE);
  wire logic hit_two = (reg_addr == `MPC_OFS_SETUP_TWO);
  wire logic hit_any = hit_pin | hit_one | hit_two;
  wire logic wr_pin = reg_wr_en & hit_pin;
  wire logic wr_one = reg_wr_en & hit_one;
  wire logic wr_two = reg_wr_en & hit_two;

  // all bits are stored as written, reserved codes too
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hardware_pin_setup_reg <= `MPC_RST_PIN_SETUP;
      device_setup_one_reg <= `MPC_RST_SETUP_ONE;
      device_setup_two_reg <= `MPC_RST_SETUP_TWO;
    end else begin
      if (wr_pin) begin
        hardware_pin_setup_reg <= reg_wdata;
      end
      if (wr_one) begin
        device_setup_one_reg <= reg_wdata;
      end
      if (wr_two) begin
        device_setup_two_reg <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // read mux; unmapped offsets read zero and flag an error
  wire logic [31:0] rd_mux =
    hit_pin ? hardware_pin_setup_reg :
    hit_one ? device_setup_one_reg :
    hit_two ? device_setup_two_reg : 32'h0000_0000;

  logic [31:0] rdata_reg;
  logic rd_valid_reg;
  logic rd_err_reg;

  // one-cycle registered answer to each read strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
      rd_err_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd_en;
      rd_err_reg <= reg_rd_en & ~hit_any;
      if (reg_rd_en) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign reg_rd_err = rd_err_reg;

  // ****************************************************************
  // brake pin synchroniser
  // ****************************************************************
  logic brake_pin_level;

  mpc_pin_sync u_brake_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_async(brake_pin),
    .pin_level(brake_pin_level)
  );

  // ****************************************************************
  // field extraction
  // ****************************************************************
  wire mpc_brake_src_t brake_src =
    mpc_brake_src_t'(hardware_pin_setup_reg[`MPC_BRAKE_SRC_LSB +: 2]);
  wire logic brake_mode_align =
    hardware_pin_setup_reg[`MPC_BRAKE_MODE_BIT];
  wire mpc_speed_t speed_mode =
    mpc_speed_t'(hardware_pin_setup_reg[`MPC_SPEED_LSB +: 2]);
  wire mpc_pin38_t pin38_route =
    mpc_pin38_t'(device_setup_one_reg[`MPC_PIN38_LSB +: 2]);
  wire logic mon_pair_on = device_setup_one_reg[`MPC_MON_PAIR_BIT];
  wire mpc_supply_t supply_code =
    mpc_supply_t'(device_setup_one_reg[`MPC_SUPPLY_LSB +: 2]);

  // ****************************************************************
  // brake source and action
  // ****************************************************************
  // codes 0 and 3 follow the pin, 1 forces, 2 never brakes
  wire logic brake_req =
    ((brake_src == MPC_BRK_PIN) |
     (brake_src == MPC_BRK_PIN_ALT)) ? brake_pin_level :
    (brake_src == MPC_BRK_FORCE);
  // mode bit picks low-side or align braking for any request
  wire logic low_side_next = brake_req & ~brake_mode_align;
  wire logic align_next = brake_req & brake_mode_align;

  // ****************************************************************
  // speed mode decode
  // ****************************************************************
  // code 2 selects no interpretation at all
  wire logic spd_analog_next = (speed_mode == MPC_SPEED_ANALOG);
  wire logic spd_pwm_next = (speed_mode == MPC_SPEED_PWM);
  wire logic spd_freq_next = (speed_mode == MPC_SPEED_FREQ);

  // ****************************************************************
  // pin routing
  // ****************************************************************
  // the pair bit cleared is reserved: monitor pins stay unused
  wire logic mon_one_next = mon_pair_on;
  wire logic mon_two_next = mon_pair_on;
  // pin 38 carries monitor two or one phase current sense
  wire logic p38_mon_next = (pin38_route == MPC_P38_MON_TWO);
  wire logic sense_a_next = (pin38_route == MPC_P38_SENSE_A);
  wire logic sense_b_next = (pin38_route == MPC_P38_SENSE_B);
  wire logic sense_c_next = (pin38_route == MPC_P38_SENSE_C);

  // ****************************************************************
  // supply full-scale
  // ****************************************************************
  // undefined code gives zero volts and drops the valid flag
  wire logic [6:0] supply_next =
    (supply_code == MPC_SUP_15) ? `MPC_VOLT_15 :
    (supply_code == MPC_SUP_30) ? `MPC_VOLT_30 :
    (supply_code == MPC_SUP_60) ? `MPC_VOLT_60 : 7'h00;
  wire logic supply_ok_next = (supply_code != MPC_SUP_UNDEF);

  // ****************************************************************
  // registered control outputs
  // ****************************************************************
  logic low_side_reg;
  logic align_reg;
  logic spd_analog_reg;
  logic spd_pwm_reg;
  logic spd_freq_reg;
  logic mon_one_reg;
  logic mon_two_reg;
  logic p38_mon_reg;
  logic sense_a_reg;
  logic sense_b_reg;
  logic sense_c_reg;
  logic [6:0] supply_reg;
  logic supply_ok_reg;

  // one flop stage keeps decode glitches off the pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_side_reg <= 1'b0;
      align_reg <= 1'b0;
      spd_analog_reg <= 1'b0;
      spd_pwm_reg <= 1'b0;
      spd_freq_reg <= 1'b0;
      mon_one_reg <= 1'b0;
      mon_two_reg <= 1'b0;
      p38_mon_reg <= 1'b0;
      sense_a_reg <= 1'b0;
      sense_b_reg <= 1'b0;
      sense_c_reg <= 1'b0;
      supply_reg <= 7'h00;
      supply_ok_reg <= 1'b0;
    end else begin
      low_side_reg <= low_side_next;
      align_reg <= align_next;
      spd_analog_reg <= spd_analog_next;
      spd_pwm_reg <= spd_pwm_next;
      spd_freq_reg <= spd_freq_next;
      mon_one_reg <= mon_one_next;
      mon_two_reg <= mon_two_next;
      p38_mon_reg <= p38_mon_next;
      sense_a_reg <= sense_a_next;
      sense_b_reg <= sense_b_next;
      sense_c_reg <= sense_c_next;
      supply_reg <= supply_next;
      supply_ok_reg <= supply_ok_next;
    end
  end

  assign low_side_brake_on = low_side_reg;
  assign align_brake_on = align_reg;
  assign speed_analog_sel = spd_analog_reg;
  assign speed_pwm_sel = spd_pwm_reg;
  assign speed_freq_sel = spd_freq_reg;
  assign analog_monitor_one_en = mon_one_reg;
  assign analog_monitor_two_en = mon_two_reg;
  assign analog_monitor_two_on_pin38 = p38_mon_reg;
  assign phase_a_sense_out_en = sense_a_reg;
  assign phase_b_sense_out_en = sense_b_reg;
  assign phase_c_sense_out_en = sense_c_reg;
  assign supply_full_scale = supply_reg;
  assign supply_scale_valid = supply_ok_reg;

  // address and second register are plain register views
  assign target_addr =
    device_setup_one_reg[`MPC_ADDR_MSB:`MPC_ADDR_LSB];
  assign device_setup_two_q = device_setup_two_reg;

endmodule : mpc_config_regs

// file: common/mpc_consts.svh
/*
 * constants of the motor pin and device configuration register bank:
 * register offsets, field positions, reset values and supply full-scale volt values.
 * assumes it is included by bare name after the package is compiled.
 */
// Contract
// - brake field: codes 0,3 pin; 1 override; 2 none
// - speed field: analog, pwm, none, frequency
// - pin 38 field: monitor two or phase sense
// - bit 27 set: both analog monitor pins
// - supply field: 15, 30, 60 V, code 3 undefined
// - override brake: mode bit low-side or align
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define MPC_OFS_PIN_SETUP 8'hA4
`define MPC_OFS_SETUP_ONE 8'hA6
`define MPC_OFS_SETUP_TWO 8'hA8

// ****************************************************************
// reset values
// ****************************************************************
// pin and setup-one reset to an undefined value in silicon; zero here
`define MPC_RST_PIN_SETUP 32'h0000_0000
`define MPC_RST_SETUP_ONE 32'h0000_0000
`define MPC_RST_SETUP_TWO 32'h0000_0000

// ****************************************************************
// field positions, hardware_pin_setup
// ****************************************************************
`define MPC_SPEED_LSB 0
`define MPC_BRAKE_SRC_LSB 2
`define MPC_BRAKE_MODE_BIT 5

// ****************************************************************
// field positions, device_setup_one
// ****************************************************************
`define MPC_SUPPLY_LSB 0
`define MPC_ADDR_LSB 20
`define MPC_ADDR_MSB 26
`define MPC_MON_PAIR_BIT 27
`define MPC_PIN38_LSB 28

// ****************************************************************
// supply full-scale values in volts
// ****************************************************************
`define MPC_VOLT_15 7'h0F
`define MPC_VOLT_30 7'h1E
`define MPC_VOLT_60 7'h3C

`endif

// file: common/mpc_pkg.sv
/*
 * types of the motor pin and device configuration register bank.
 * assumes nothing of its surroundings.
 */
package mpc_pkg;

  // speed pin interpretation codes
  typedef enum logic [1:0] {
    MPC_SPEED_ANALOG = 2'h0,
    MPC_SPEED_PWM = 2'h1,
    MPC_SPEED_NONE = 2'h2,
    MPC_SPEED_FREQ = 2'h3
  } mpc_speed_t;

  // brake source codes
  typedef enum logic [1:0] {
    MPC_BRK_PIN = 2'h0,
    MPC_BRK_FORCE = 2'h1,
    MPC_BRK_NEVER = 2'h2,
    MPC_BRK_PIN_ALT = 2'h3
  } mpc_brake_src_t;

  // multi-function pin 38 routing codes
  typedef enum logic [1:0] {
    MPC_P38_MON_TWO = 2'h0,
    MPC_P38_SENSE_A = 2'h1,
    MPC_P38_SENSE_B = 2'h2,
    MPC_P38_SENSE_C = 2'h3
  } mpc_pin38_t;

  // supply full-scale codes
  typedef enum logic [1:0] {
    MPC_SUP_15 = 2'h0,
    MPC_SUP_30 = 2'h1,
    MPC_SUP_60 = 2'h2,
    MPC_SUP_UNDEF = 2'h3
  } mpc_supply_t;

endpackage : mpc_pkg

// file: src/mpc_pin_sync.sv
/*
 * three-stage synchroniser with agreement filter for one pin.
 * assumes the pin is asynchronous to sys_clk.
 */
`timescale 1ns/1ns
module mpc_pin_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pin_async,
  output logic pin_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  wire logic agree = (s2_reg == s3_reg); // first stage never looked at

  // ****************************************************************
  // shift chain and filtered level
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign pin_level = level_reg;

endmodule : mpc_pin_sync

// file: test/mpc_config_regs_properties.sv
/* port checks for the configuration register bank.
   assumes binding to mpc_config_regs, strobes low in reset. */
`timescale 1ns/1ns
`include "mpc_consts.svh"
module mpc_config_regs_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic reg_rd_err,
  input wire logic low_side_brake_on,
  input wire logic align_brake_on,
  input wire logic speed_analog_sel,
  input wire logic speed_pwm_sel,
  input wire logic speed_freq_sel,
  input wire logic analog_monitor_one_en,
  input wire logic analog_monitor_two_en,
  input wire logic analog_monitor_two_on_pin38,
  input wire logic phase_a_sense_out_en,
  input wire logic phase_b_sense_out_en,
  input wire logic phase_c_sense_out_en,
  input wire logic [6:0] supply_full_scale,
  input wire logic supply_scale_valid,
  input wire logic [31:0] device_setup_two_q
);
  // ****************************************************************
  // write decode helpers
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire mapped = reg_addr inside {`MPC_OFS_PIN_SETUP, `MPC_OFS_SETUP_ONE,
    `MPC_OFS_SETUP_TWO};
  wire wr_pin = reg_wr_en && reg_addr == `MPC_OFS_PIN_SETUP;
  wire wr_one = reg_wr_en && reg_addr == `MPC_OFS_SETUP_ONE;
  wire wr_two = reg_wr_en && reg_addr == `MPC_OFS_SETUP_TWO;
  wire [1:0] sc = reg_wdata[1:0];
  wire [2:0] spd_hot = {sc == 2'h3, sc == 2'h1, sc == 2'h0};
  wire [3:0] p38_hot = 4'h1 << reg_wdata[29:28];
  // code 3 gives zero volts, so the valid flag must drop with it
  wire [6:0] volt = sc == 2'h0 ? 7'h0F : sc == 2'h1 ? 7'h1E :
    sc == 2'h2 ? 7'h3C : 7'h00;
  // a gap cycle before the read keeps the stored word unambiguous
  property p_back;
    logic [31:0] d;
    logic [7:0] a;
    (reg_wr_en && mapped, d = reg_wdata, a = reg_addr) ##1 !reg_wr_en
      ##1 (reg_rd_en && reg_addr == a) |=> reg_rdata == d;
  endproperty
  // ****************************************************************
  // assertions
  // ****************************************************************
  rd_pulse_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read answer timing wrong");
  rd_err_a: assert property (reg_rd_en |=>
    reg_rd_err == !$past(mapped))
    else $error("read error flag wrong");
  read_back_a: assert property (p_back)
    else $error("stored word not returned");
  speed_mode_a: assert property (wr_pin |-> ##2
    {speed_freq_sel, speed_pwm_sel, speed_analog_sel} == $past(spd_hot, 2))
    else $error("speed select wrong");
  brake_force_a: assert property (wr_pin &&
    reg_wdata[3:2] == 2'h1
    |-> ##2 align_brake_on == $past(reg_wdata[5], 2)
    && low_side_brake_on == !$past(reg_wdata[5], 2))
    else $error("forced brake action wrong");
  brake_never_a: assert property (wr_pin && reg_wdata[3:2] == 2'h2
    |-> ##2 !low_side_brake_on && !align_brake_on)
    else $error("brake with override off");
  pin_route_a: assert property (wr_one |-> ##2 {phase_c_sense_out_en,
    phase_b_sense_out_en, phase_a_sense_out_en,
    analog_monitor_two_on_pin38} == $past(p38_hot, 2))
    else $error("pin 38 routing wrong");
  mon_pair_a: assert property (wr_one |-> ##2
    analog_monitor_one_en == $past(reg_wdata[27], 2)
    && analog_monitor_two_en == $past(reg_wdata[27], 2))
    else $error("monitor pair wrong");
  supply_sel_a: assert property (wr_one |-> ##2
    supply_full_scale == $past(volt, 2)
    && supply_scale_valid == ($past(sc, 2) != 2'h3))
    else $error("supply scale wrong");
  setup_two_a: assert property (wr_two |=>
    device_setup_two_q == $past(reg_wdata))
    else $error("second setup word wrong");
  cover property (reg_rd_err);
  cover property (low_side_brake_on);
  cover property (align_brake_on);
endmodule : mpc_config_regs_properties
bind mpc_config_regs mpc_config_regs_properties u_props (.*);

// file: test/mpc_config_regs_tb.sv
/* self-checking bench for the configuration register bank.
   assumes design and checker are compiled before it. */
`timescale 1ns/1ns
`include "mpc_consts.svh"
module mpc_config_regs_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_rd_en = 1'b0;
  logic brake_pin = 1'b0;
  logic [31:0] reg_rdata, device_setup_two_q, r;
  logic reg_rd_valid, reg_rd_err, low_side_brake_on, align_brake_on;
  logic speed_analog_sel, speed_pwm_sel, speed_freq_sel, bk;
  logic analog_monitor_one_en, analog_monitor_two_en, supply_scale_valid;
  logic analog_monitor_two_on_pin38, phase_a_sense_out_en;
  logic phase_b_sense_out_en, phase_c_sense_out_en;
  logic [6:0] supply_full_scale, target_addr, v;
  logic [32:0] exp_q[$];
  logic [32:0] e_n;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'hFFC4;
  int i;
  always #5 sys_clk = ~sys_clk;
  mpc_config_regs DUT (.*);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  // write strobe lasts one cycle, decode settles two edges later
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
  endtask : rd
  // watcher: each read answer takes the oldest note
  always @(negedge sys_clk) begin
    if (reg_rd_valid === 1'b1) begin
      e_n = exp_q.pop_front();
      chk("rdata", e_n[31:0], reg_rdata);
      chk("rd_err", {31'h0, e_n[32]}, {31'h0, reg_rd_err});
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    // decode outputs show the reset contents only after one edge
    @(negedge sys_clk);
    chk("reset scale", 32'h0F, {25'h0, supply_full_scale});
    rd(`MPC_OFS_PIN_SETUP, 33'h0);
    rd(`MPC_OFS_SETUP_TWO, 33'h0);
    // pin setup: every speed, brake and mode code, random pin level
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      r[5:0] = {i[4], r[4], i[3:0]};
      brake_pin = r[31];
      wr(`MPC_OFS_PIN_SETUP, r);
      bk = (r[3:2] == 2'h0 || r[3:2] == 2'h3) ? r[31] : r[3:2] == 2'h1;
      chk("speed",
        {29'h0, r[1:0] == 2'h3, r[1:0] == 2'h1, r[1:0] == 2'h0},
        {29'h0, speed_freq_sel, speed_pwm_sel, speed_analog_sel});
      chk("brake", {30'h0, bk & r[5], bk & ~r[5]},
        {30'h0, align_brake_on, low_side_brake_on});
      rd(`MPC_OFS_PIN_SETUP, {1'b0, r});
    end
    // setup one: every routing and supply code
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      r[29:28] = i[1:0];
      r[1:0] = i[3:2];
      wr(`MPC_OFS_SETUP_ONE, r);
      v = r[1:0] == 2'h0 ? 7'h0F : r[1:0] == 2'h1 ? 7'h1E :
        r[1:0] == 2'h2 ? 7'h3C : 7'h00;
      chk("pin38", 32'h1 << r[29:28],
        {28'h0, phase_c_sense_out_en, phase_b_sense_out_en,
        phase_a_sense_out_en, analog_monitor_two_on_pin38});
      chk("monitors", {30'h0, r[27], r[27]},
        {30'h0, analog_monitor_one_en, analog_monitor_two_en});
      chk("scale", {24'h0, r[1:0] != 2'h3, v},
        {24'h0, supply_scale_valid, supply_full_scale});
      chk("target", {25'h0, r[26:20]}, {25'h0, target_addr});
      rd(`MPC_OFS_SETUP_ONE, {1'b0, r});
    end
    // setup two, then unmapped writes must leave it alone
    r = $random(seed);
    wr(`MPC_OFS_SETUP_TWO, r);
    chk("setup two", r, device_setup_two_q);
    wr(8'hAA, ~r);
    wr(8'hA5, ~r);
    rd(8'hA5, {1'b1, 32'h0});
    rd(`MPC_OFS_SETUP_TWO, {1'b0, r});
    // write then read after one gap cycle: the read-back window
    @(negedge sys_clk);
    reg_addr = `MPC_OFS_SETUP_TWO;
    reg_wdata = ~r;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    rd(`MPC_OFS_SETUP_TWO, {1'b0, ~r});
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge sys_clk);
    if (exp_q.size() > 0) chk("drain", 32'h0, 32'h1);
    summarize();
  end
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    chk("watchdog", 32'h0, 32'h1);
    summarize();
  end
endmodule : mpc_config_regs_tb
